// ==== dmc_pkg.sv ====
// Package: constants and carrier types for the display memory clear / auto-increment block
package dmc_pkg;

    // ------------------------------------------------------------
    // Register addresses (write address; read address adds 0x80)
    // ------------------------------------------------------------
    localparam logic [6:0] DMC_ADDR_VM0 = 7'h00;
    localparam logic [6:0] DMC_ADDR_MODE = 7'h04;
    localparam logic [6:0] DMC_ADDR_AHI = 7'h05;
    localparam logic [6:0] DMC_ADDR_ALO = 7'h06;
    localparam logic [6:0] DMC_ADDR_DIN = 7'h07;
    localparam int DMC_READ_BIT = 7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DMC_MODE_AUTOINC = 0;
    localparam int DMC_MODE_VSCLR = 1;
    localparam int DMC_MODE_CLEAR = 2;
    localparam int DMC_MODE_ATTR_LO = 3;
    localparam int DMC_MODE_WIDTH8 = 6;
    localparam int DMC_AHI_MSB = 0;
    localparam int DMC_AHI_BSEL = 1;
    localparam int DMC_VM0_SWRST = 1;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] DMC_MODE_RST = 8'h00;
    localparam logic [7:0] DMC_ESCAPE = 8'hFF;
    localparam int DMC_DEPTH = 512;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int DMC_CLK_MHZ = 125;
    localparam int DMC_CLEAR_US = 20;
    localparam int DMC_CLEAR_CYC = DMC_CLEAR_US * DMC_CLK_MHZ;

    // One memory write request
    typedef struct packed {
        logic we;
        logic [8:0] addr;
        logic [7:0] code;
        logic [7:0] attr;
        logic code_en;
        logic attr_en;
    } dmc_wr_t;

endpackage

// ==== dmc_spi_rx.sv ====
// Serial byte receiver: shifts host bytes in on sclk edges while cs is low
`timescale 1ns/1ps
module dmc_spi_rx (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdin,
    output logic [7:0] byte_data,
    output logic byte_valid,
    output logic byte_first,
    output logic cs_rise
);
    logic sclk_d_r;
    logic cs_d_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic first_r;

    // Sclk and cs are already synchronous; edge detect only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk;
            cs_d_r <= cs_n;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r <= 3'h0;
            shift_r <= 7'h00;
            first_r <= 1'b1;
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            byte_first <= 1'b0;
        end else begin
            byte_valid <= 1'b0;
            if (cs_n) begin
                bit_cnt_r <= 3'h0;
                first_r <= 1'b1;
            end else if (sclk && !sclk_d_r) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                shift_r <= {shift_r[5:0], sdin};
                if (bit_cnt_r == 3'h7) begin
                    byte_data <= {shift_r, sdin};
                    byte_valid <= 1'b1;
                    byte_first <= first_r;
                    first_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cs_rise <= 1'b0;
        end else begin
            cs_rise <= cs_n && !cs_d_r;
        end
    end
endmodule

// ==== dmc_core.sv ====
// Display memory mode control: clear sequencing, auto-increment writes, register access
//
// Contract
// - Clear command fills display memory with zeros
// - Clear bit self-returns to zero after fill
// - Mode register read shows live clear bit
// - Clear runs by itself at power-up
// - Clear starts right after reset release
// - Software reset clears after chip-select rises
// - Vsync-clear bit matters only during clear
// - Vsync-clear defers fill to next vsync
// - Auto-increment advances address after each byte
// - Auto-increment starts at current address registers
// - Auto-increment bytes carry no address phase
// - Byte-select steers code or attribute byte
// - Escape byte all ones leaves auto-increment
// - 0xFF storable only outside auto-increment
// - Byte-select used only in 8-bit mode
// - 16-bit mode copies mode attribute bits
`timescale 1ns/1ps
module dmc_core #(
    parameter int CLEAR_CYC = dmc_pkg::DMC_CLEAR_CYC,
    parameter int DEPTH = dmc_pkg::DMC_DEPTH
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic vsync,
    output logic sdout,
    output logic sdout_oe,
    output logic clear_busy,
    output logic [7:0] mode_reg,
    output logic [8:0] dm_addr,
    output logic dm_we,
    output logic [7:0] dm_code,
    output logic [7:0] dm_attr,
    output logic dm_code_en,
    output logic dm_attr_en
);
    typedef enum logic [1:0] {
        DMC_IDLE = 2'b00,
        DMC_WAIT_VS = 2'b01,
        DMC_FILL = 2'b10
    } dmc_state_t;

    localparam int CW = $clog2(CLEAR_CYC + 1);

    dmc_state_t state_r;
    logic [CW-1:0] clr_cnt_r;
    logic [8:0] fill_addr_r;
    logic [7:0] mode_r;
    logic [7:0] ahi_r;
    logic [7:0] alo_r;
    logic [8:0] ai_addr_r;
    logic ai_active_r;
    logic swrst_pend_r;
    logic rd_pend_r;
    logic [7:0] reg_sel_r;
    logic [7:0] tx_r;
    logic sclk_d_r;
    logic vsync_d_r;
    dmc_pkg::dmc_wr_t wr_nxt;
    dmc_pkg::dmc_wr_t wr_r;

    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_first;
    logic cs_rise;
    logic clr_req;
    logic clr_done;
    logic vs_edge;
    logic reg_wr;
    logic data_byte;

    dmc_spi_rx u_rx (
        .core_clk(core_clk),
        .resetn(resetn),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdin(sdin),
        .byte_data(rx_byte),
        .byte_valid(rx_valid),
        .byte_first(rx_first),
        .cs_rise(cs_rise)
    );

    // ------------------------------------------------------------
    // Host byte decode
    // ------------------------------------------------------------
    // Auto-increment frames send a bare data byte as the first byte of every frame
    assign data_byte = rx_valid && ai_active_r && rx_first;
    assign reg_wr = rx_valid && !rx_first && !reg_sel_r[dmc_pkg::DMC_READ_BIT] && !ai_active_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_sel_r <= 8'h00;
        end else if (rx_valid && rx_first && !ai_active_r) begin
            reg_sel_r <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Clear sequencer
    // ------------------------------------------------------------
    assign vs_edge = vsync && !vsync_d_r;
    assign clr_req = reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_MODE && rx_byte[dmc_pkg::DMC_MODE_CLEAR];
    assign clr_done = state_r == DMC_FILL && clr_cnt_r == CW'(CLEAR_CYC - 1);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            vsync_d_r <= 1'b0;
        end else begin
            vsync_d_r <= vsync;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            swrst_pend_r <= 1'b0;
        end else if (cs_rise) begin
            swrst_pend_r <= 1'b0;
        end else if (reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_VM0 && rx_byte[dmc_pkg::DMC_VM0_SWRST]) begin
            swrst_pend_r <= 1'b1;
        end
    end

    // Reset leaves the sequencer in FILL: power-up and reset-release clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= DMC_FILL;
            clr_cnt_r <= '0;
        end else begin
            case (state_r)
                DMC_IDLE: begin
                    clr_cnt_r <= '0;
                    if (cs_rise && swrst_pend_r) begin
                        state_r <= DMC_FILL;
                    end else if (clr_req && rx_byte[dmc_pkg::DMC_MODE_VSCLR]) begin
                        state_r <= DMC_WAIT_VS;
                    end else if (clr_req) begin
                        state_r <= DMC_FILL;
                    end
                end
                DMC_WAIT_VS: begin
                    if (vs_edge) begin
                        state_r <= DMC_FILL;
                    end
                end
                DMC_FILL: begin
                    clr_cnt_r <= clr_cnt_r + CW'(1);
                    if (clr_done) begin
                        state_r <= DMC_IDLE;
                    end
                end
                default: begin
                    state_r <= DMC_IDLE;
                end
            endcase
        end
    end

    // Fill walks every location; wraps until the timed span ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fill_addr_r <= 9'h000;
        end else if (state_r == DMC_FILL) begin
            fill_addr_r <= (fill_addr_r == 9'(DEPTH - 1)) ? 9'h000 : fill_addr_r + 9'h001;
        end else begin
            fill_addr_r <= 9'h000;
        end
    end

    // ------------------------------------------------------------
    // Mode, address registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= dmc_pkg::DMC_MODE_RST;
        end else begin
            if (reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_MODE) begin
                // Bit 2 held zero here; the live clear bit comes from the sequencer
                mode_r <= {rx_byte[7:3], 1'b0,
                           rx_byte[dmc_pkg::DMC_MODE_VSCLR] & rx_byte[dmc_pkg::DMC_MODE_CLEAR],
                           rx_byte[dmc_pkg::DMC_MODE_AUTOINC]};
            end
            if (rx_valid && ai_active_r && rx_first && rx_byte == dmc_pkg::DMC_ESCAPE) begin
                mode_r[dmc_pkg::DMC_MODE_AUTOINC] <= 1'b0;
            end
            if (clr_done) begin
                mode_r[dmc_pkg::DMC_MODE_VSCLR] <= 1'b0;
            end
        end
    end

    // Writes during a clear are the host's fault; accepted without guard
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ahi_r <= 8'h00;
            alo_r <= 8'h00;
        end else if (reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_AHI) begin
            ahi_r <= rx_byte;
        end else if (reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_ALO) begin
            alo_r <= rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Auto-increment pointer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ai_active_r <= 1'b0;
            ai_addr_r <= 9'h000;
        end else if (!mode_r[dmc_pkg::DMC_MODE_AUTOINC]) begin
            ai_active_r <= 1'b0;
        end else if (!ai_active_r && cs_n) begin
            ai_active_r <= 1'b1;
            ai_addr_r <= {ahi_r[dmc_pkg::DMC_AHI_MSB], alo_r};
        end else if (data_byte && rx_byte != dmc_pkg::DMC_ESCAPE) begin
            ai_addr_r <= ai_addr_r + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Memory write path
    // ------------------------------------------------------------
    always_comb begin
        wr_nxt = '0;
        if (state_r == DMC_FILL) begin
            wr_nxt.we = 1'b1;
            wr_nxt.addr = fill_addr_r;
            wr_nxt.code_en = 1'b1;
            wr_nxt.attr_en = 1'b1;
        end else if ((data_byte && rx_byte != dmc_pkg::DMC_ESCAPE) ||
                     (reg_wr && reg_sel_r[6:0] == dmc_pkg::DMC_ADDR_DIN)) begin
            wr_nxt.we = 1'b1;
            wr_nxt.addr = ai_active_r ? ai_addr_r : {ahi_r[dmc_pkg::DMC_AHI_MSB], alo_r};
            if (mode_r[dmc_pkg::DMC_MODE_WIDTH8]) begin
                wr_nxt.code_en = !ahi_r[dmc_pkg::DMC_AHI_BSEL];
                wr_nxt.attr_en = ahi_r[dmc_pkg::DMC_AHI_BSEL];
                wr_nxt.code = rx_byte;
                wr_nxt.attr = rx_byte;
            end else begin
                wr_nxt.code_en = 1'b1;
                wr_nxt.attr_en = 1'b1;
                wr_nxt.code = rx_byte;
                wr_nxt.attr = {mode_r[dmc_pkg::DMC_MODE_ATTR_LO +: 3], 5'h00};
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_r <= '0;
        end else begin
            wr_r <= wr_nxt;
        end
    end

    assign dm_we = wr_r.we;
    assign dm_addr = wr_r.addr;
    assign dm_code = wr_r.code;
    assign dm_attr = wr_r.attr;
    assign dm_code_en = wr_r.code_en;
    assign dm_attr_en = wr_r.attr_en;

    // ------------------------------------------------------------
    // Status and read-back
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clear_busy <= 1'b1;
            mode_reg <= dmc_pkg::DMC_MODE_RST;
        end else begin
            clear_busy <= wr_nxt.we && state_r == DMC_FILL || state_r == DMC_WAIT_VS;
            mode_reg <= {mode_r[7:3], state_r != DMC_IDLE && !clr_done, mode_r[1:0]};
        end
    end

    // Read data shifts out MSB first on falling sclk
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d_r <= 1'b0;
            rd_pend_r <= 1'b0;
            tx_r <= 8'h00;
            sdout <= 1'b0;
            sdout_oe <= 1'b0;
        end else begin
            sclk_d_r <= sclk;
            // Load as the address byte lands: the first falling sclk may follow one cycle later
            if (rx_valid && rx_first && !ai_active_r && rx_byte[dmc_pkg::DMC_READ_BIT]) begin
                rd_pend_r <= 1'b1;
                case (rx_byte[6:0])
                    dmc_pkg::DMC_ADDR_MODE: tx_r <= mode_reg;
                    dmc_pkg::DMC_ADDR_AHI: tx_r <= ahi_r;
                    dmc_pkg::DMC_ADDR_ALO: tx_r <= alo_r;
                    default: tx_r <= 8'h00;
                endcase
            end else if (rd_pend_r && !sclk && sclk_d_r) begin
                sdout <= tx_r[7];
                sdout_oe <= 1'b1;
                tx_r <= {tx_r[6:0], 1'b0};
            end
            if (cs_n) begin
                rd_pend_r <= 1'b0;
                sdout_oe <= 1'b0;
            end
        end
    end
endmodule

// ==== dmc_core_checker.sv ====
// Checker: port-level properties of the display memory clear and auto-increment block
`timescale 1ns/1ps
module dmc_core_checker #(
    parameter int CLEAR_CYC = dmc_pkg::DMC_CLEAR_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic vsync,
    input wire logic clear_busy,
    input wire logic [7:0] mode_reg,
    input wire logic [8:0] dm_addr,
    input wire logic dm_we,
    input wire logic [7:0] dm_code,
    input wire logic [7:0] dm_attr,
    input wire logic dm_code_en,
    input wire logic dm_attr_en
);
    logic [15:0] run_r;
    logic [8:0] last_r;
    logic seen_r;
    logic user_we;
    assign user_we = dm_we && !clear_busy;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_r <= 16'h0000;
        end else if (!clear_busy) begin
            run_r <= 16'h0000;
        end else if (dm_we) begin
            run_r <= run_r + 16'h0001;
        end
    end
    // Pointer history only counts inside one auto-increment session
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seen_r <= 1'b0;
            last_r <= 9'h000;
        end else if (!mode_reg[0]) begin
            seen_r <= 1'b0;
        end else if (user_we) begin
            seen_r <= 1'b1;
            last_r <= dm_addr;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_rst_fill;
        $rose(resetn) |-> ##[0:2] (dm_we && clear_busy);
    endproperty
    a_rst_fill: assert property (p_rst_fill) else $error("no fill after reset release");
    property p_fill_zero;
        dm_we && clear_busy |-> dm_code == 8'h00 && dm_attr == 8'h00 && dm_code_en && dm_attr_en;
    endproperty
    a_fill_zero: assert property (p_fill_zero) else $error("fill wrote nonzero data");
    property p_fill_len;
        run_r <= CLEAR_CYC + 1;
    endproperty
    a_fill_len: assert property (p_fill_len) else $error("fill ran too long");
    property p_vs_start;
        $rose(vsync) && clear_busy && !dm_we |-> ##[1:4] dm_we;
    endproperty
    a_vs_start: assert property (p_vs_start) else $error("deferred fill did not start at vsync");
    property p_autoinc;
        user_we && mode_reg[0] && seen_r |-> dm_addr == last_r + 9'h001;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("pointer did not advance by one");
    property p_no_escape;
        // Mode bit still reads one when an escape write would show; mode_reg lags mode_r by a cycle
        user_we && (mode_reg[0] || seen_r) |-> !(dm_code_en && dm_code == 8'hFF);
    endproperty
    a_no_escape: assert property (p_no_escape) else $error("escape code stored");
    property p_attr16;
        user_we && !mode_reg[6] |-> dm_code_en && dm_attr_en && dm_attr == {mode_reg[5:3], 5'h00};
    endproperty
    a_attr16: assert property (p_attr16) else $error("wide mode attribute wrong");
    property p_sel8;
        user_we && mode_reg[6] |-> dm_code_en != dm_attr_en;
    endproperty
    a_sel8: assert property (p_sel8) else $error("narrow mode wrote both bytes");
    c_fill: cover property ($rose(clear_busy));
    c_vs: cover property ($rose(vsync) && clear_busy && !dm_we);
    c_auto: cover property (user_we && mode_reg[0] && seen_r);
endmodule
bind dmc_core dmc_core_checker #(.CLEAR_CYC(CLEAR_CYC)) dmc_core_checker_inst (.core_clk(core_clk),
    .resetn(resetn), .vsync(vsync), .clear_busy(clear_busy), .mode_reg(mode_reg), .dm_addr(dm_addr),
    .dm_we(dm_we), .dm_code(dm_code), .dm_attr(dm_attr), .dm_code_en(dm_code_en), .dm_attr_en(dm_attr_en));

// ==== dmc_host_model.sv ====
// Host controller model: drives serial frames and samples read data
`timescale 1ns/1ps
module dmc_host_model (
    input wire logic core_clk,
    input wire logic sdout,
    output logic cs_n,
    output logic sclk,
    output logic sdin
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdin = 1'b0;
    end
    task automatic half();
        repeat (2) @(negedge core_clk);
    endtask
    // Bit time of four core cycles; sclk idles low between frames
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int n, output logic [7:0] r);
        logic [15:0] w;
        w = {b0, b1};
        r = 8'h00;
        @(negedge core_clk);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - 8 * n; i--) begin
            half();
            sdin = w[i];
            sclk = 1'b0;
            half();
            sclk = 1'b1;
            if (i < 8) r = {r[6:0], sdout};
        end
        half();
        sclk = 1'b0;
        half();
        cs_n = 1'b1;
        sdin = ~sdin; // Released line must not keep a plausible bit
        repeat (4) @(negedge core_clk);
    endtask
endmodule

// ==== tb_dmc.sv ====
// Testbench: drives frames and vsync, checks memory writes and clear timing
`timescale 1ns/1ps
module testbench;
    localparam int CLR = 20;
    logic core_clk, resetn, cs_n, sclk, sdin, vsync, sdout, sdout_oe, clear_busy, dm_we, dm_code_en, dm_attr_en;
    logic [7:0] mode_reg, dm_code, dm_attr, rd, d;
    logic [8:0] dm_addr;
    dmc_pkg::dmc_wr_t q[$];
    dmc_pkg::dmc_wr_t got;
    int error_cnt = 0;
    int n_checks = 0;
    int fill_cnt = 0;
    int oe_cnt = 0;
    int cyc = 0;
    int seed = 65015;
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    dmc_core #(.CLEAR_CYC(CLR)) dmc_core_inst (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
        .sdin(sdin), .vsync(vsync), .sdout(sdout), .sdout_oe(sdout_oe), .clear_busy(clear_busy),
        .mode_reg(mode_reg), .dm_addr(dm_addr), .dm_we(dm_we), .dm_code(dm_code), .dm_attr(dm_attr),
        .dm_code_en(dm_code_en), .dm_attr_en(dm_attr_en));
    dmc_host_model dmc_host_model_inst (.core_clk(core_clk), .sdout(sdout), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_wr(input dmc_pkg::dmc_wr_t e, input dmc_pkg::dmc_wr_t g);
        cmp_val("wr_addr", {7'h00, e.addr}, {7'h00, g.addr});
        cmp_val("wr_en", {14'h0000, e.code_en, e.attr_en}, {14'h0000, g.code_en, g.attr_en});
        if (e.code_en) cmp_val("wr_code", {8'h00, e.code}, {8'h00, g.code});
        if (e.attr_en) cmp_val("wr_attr", {8'h00, e.attr}, {8'h00, g.attr});
    endtask
    // Writes with no note queued are fill cycles while clear_busy is high, stray writes otherwise
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
        if (sdout_oe === 1'b1) oe_cnt++;
        if (resetn === 1'b1 && dm_we === 1'b1) begin
            got = '{dm_we, dm_addr, dm_code, dm_attr, dm_code_en, dm_attr_en};
            if (q.size() == 0 && clear_busy === 1'b1) begin
                cmp_val("fill_addr", fill_cnt[15:0], {7'h00, dm_addr});
                cmp_val("fill_data", 16'h0000, {dm_code, dm_attr});
                fill_cnt++;
            end else if (q.size() == 0) begin
                cmp_val("stray_wr", 16'h0000, 16'h0001);
            end else begin
                cmp_wr(q.pop_front(), got);
            end
        end
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        dmc_host_model_inst.frame({1'b0, a}, v, 2, rd);
    endtask
    task automatic push(input logic [8:0] a, input logic [7:0] c, input logic [7:0] t, input logic ce, input logic te);
        q.push_back('{1'b1, a, c, t, ce, te});
    endtask
    task automatic vs_pulse();
        @(negedge core_clk);
        vsync = 1'b1;
        repeat (3) @(negedge core_clk);
        vsync = 1'b0;
    endtask
    // Host stays off the address and data registers until this returns
    task automatic wait_idle(input int exp);
        int n;
        n = 0;
        while (clear_busy !== 1'b0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        repeat (4) @(negedge core_clk);
        cmp_val("fill_cycles", exp[15:0], fill_cnt[15:0]);
        cmp_val("clear_bit", 16'h0000, {15'h0000, mode_reg[2]});
        cmp_val("busy_done", 16'h0000, {15'h0000, clear_busy});
        fill_cnt = 0;
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (20) @(negedge core_clk);
        fill_cnt = 0;
        resetn = 1'b1;
        wait_idle(CLR);
    endtask
    initial begin
        resetn = 1'b0;
        vsync = 1'b0;
        do_reset();
        wr(dmc_pkg::DMC_ADDR_MODE, 8'h04);
        wait_idle(CLR);
        wr(dmc_pkg::DMC_ADDR_MODE, 8'h02);
        vs_pulse();
        repeat (8) @(negedge core_clk);
        cmp_val("stray_fill", 16'h0000, fill_cnt[15:0]);
        wr(dmc_pkg::DMC_ADDR_MODE, 8'h06);
        dmc_host_model_inst.frame({1'b1, dmc_pkg::DMC_ADDR_MODE}, 8'h00, 2, rd);
        cmp_val("mode_wait", 16'h0006, {8'h00, rd});
        cmp_val("busy_wait", 16'h0001, {15'h0000, clear_busy});
        cmp_val("sdout_oe", 16'h0001, {15'h0000, oe_cnt > 0});
        oe_cnt = 0;
        cmp_val("early_fill", 16'h0000, fill_cnt[15:0]);
        vs_pulse();
        wait_idle(CLR);
        dmc_host_model_inst.frame({1'b1, dmc_pkg::DMC_ADDR_MODE}, 8'h00, 2, rd);
        cmp_val("mode_done", 16'h0000, {8'h00, rd});
        cmp_val("sdout_oe", 16'h0001, {15'h0000, oe_cnt > 0});
        oe_cnt = 0;
        wr(dmc_pkg::DMC_ADDR_VM0, 8'h02);
        wait_idle(CLR);
        wr(dmc_pkg::DMC_ADDR_MODE, 8'h28);
        wr(dmc_pkg::DMC_ADDR_AHI, 8'h01);
        wr(dmc_pkg::DMC_ADDR_ALO, 8'h23);
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            if (i == 1) d = 8'hFF;
            push(9'h123, d, 8'hA0, 1'b1, 1'b1);
            wr(dmc_pkg::DMC_ADDR_DIN, d);
        end
        wr(dmc_pkg::DMC_ADDR_AHI, 8'h00);
        wr(dmc_pkg::DMC_ADDR_ALO, 8'hFE);
        wr(dmc_pkg::DMC_ADDR_MODE, 8'h41);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            if (d === 8'hFF) d = 8'h5A;
            push(9'h0FE + 9'(i), d, 8'h00, 1'b1, 1'b0);
            dmc_host_model_inst.frame(d, 8'h00, 1, rd);
        end
        dmc_host_model_inst.frame(8'hFF, 8'h00, 1, rd);
        wr(dmc_pkg::DMC_ADDR_AHI, 8'h02);
        wr(dmc_pkg::DMC_ADDR_ALO, 8'h10);
        push(9'h010, 8'h00, 8'h77, 1'b0, 1'b1);
        wr(dmc_pkg::DMC_ADDR_DIN, 8'h77);
        repeat (8) @(negedge core_clk);
        cmp_val("pending", 16'h0000, 16'(q.size()));
        cmp_val("oe_idle", 16'h0000, oe_cnt[15:0]);
        do_reset();
        tally_and_finish();
    end
endmodule
